// file: rtl/dbg_unit.sv
// per-tile debug support: saved copies, cause, halt mask, scratch, ibps
// assumes single clock, pipeline reports entry and pc per core
//
// Local design decision: the plain strobed port.

module dbg_unit #(
	parameter int NCORES = 8,
	parameter int NIBP = 4,
	parameter int NSCR = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// debugger register port
	input wire dbg_unit_pkg::reg_req_t req,
	output logic [31:0] rdata,
	// tile config scratch port
	input wire logic cfg_wr,
	input wire logic [2:0] cfg_idx,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	// debug state and entry from the pipeline
	input wire logic debug_mode,
	input wire dbg_unit_pkg::entry_req_t entry,
	input wire logic [NCORES*32-1:0] core_pc,
	input wire logic [NCORES-1:0] core_pc_valid,
	// outputs to the cores
	output logic ibp_hit,
	output logic [7:0] ibp_core,
	output logic [1:0] ibp_index,
	output logic [NCORES-1:0] core_halt,
	output logic irq
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (NCORES < 1 || NCORES > 8) begin : g_bad_cores
		$error("NCORES must be 1..8");
	end
	if (NIBP != 4 || NSCR != 8) begin : g_bad_counts
		$error("field layout fixes four breakpoints and eight scratch");
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0] spc_ff, ssp_ff, evdata_ff;
	logic [7:0] rr_core_ff;
	logic [4:0] rr_idx_ff;
	logic [2:0] cause_code_ff;
	logic [7:0] cause_core_ff;
	logic [1:0] cause_idx_ff;
	logic [7:0] halt_ff;
	logic [31:0] scratch_ff [NSCR];
	logic [31:0] ibp_addr_ff [NIBP];
	logic ibp_en_ff [NIBP];
	logic ibp_inv_ff [NIBP];
	logic [7:0] ibp_cores_ff [NIBP];
	logic [1:0] irq_stat_ff, irq_mask_ff;
	logic dbg_wr;

	// decode for one register index
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	assign dbg_wr = req.wr && debug_mode;

	// ----------------------------------------------------------------
	// saved copies and event data
	// ----------------------------------------------------------------
	// entry capture wins over a same-cycle debugger write
	always_ff @(posedge clk) begin
		if (rst) begin
			spc_ff <= dbg_unit_pkg::RST_WORD;
			ssp_ff <= dbg_unit_pkg::RST_WORD;
		end else if (entry.valid) begin
			spc_ff <= entry.saved_program_counter;
			ssp_ff <= entry.saved_stack_pointer;
		end else begin
			if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_SPC)) begin
				spc_ff <= req.wdata;
			end
			if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_SSP)) begin
				ssp_ff <= req.wdata;
			end
		end
	end

	// event data follows the kind of watchpoint that fired
	always_ff @(posedge clk) begin
		if (rst) begin
			evdata_ff <= dbg_unit_pkg::RST_WORD;
		end else if (entry.valid &&
				(entry.cause == dbg_unit_pkg::CAUSE_DWP ||
				entry.cause == dbg_unit_pkg::CAUSE_RWP)) begin
			// address on data hit; resource id otherwise
			evdata_ff <= entry.ev_data;
		end else if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_EVDATA)) begin
			evdata_ff <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// remote register-read operands
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rr_core_ff <= 8'h00;
			rr_idx_ff <= 5'h00;
		end else begin
			if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_RR_CORE)) begin
				rr_core_ff <= req.wdata[7:0];
			end
			if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_RR_IDX)) begin
				rr_idx_ff <= req.wdata[4:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// instruction breakpoint match, lowest index first
	// ----------------------------------------------------------------
	logic nxt_hit;
	logic [7:0] nxt_core;
	logic [1:0] nxt_idx;
	always_comb begin
		nxt_hit = 1'b0;
		nxt_core = 8'h00;
		nxt_idx = 2'h0;
		// descending scan so the lowest index overwrites last
		for (int b = NIBP - 1; b >= 0; b--) begin
			for (int c = NCORES - 1; c >= 0; c--) begin
				if (ibp_en_ff[b] && ibp_cores_ff[b][c] && core_pc_valid[c]
					&& ((core_pc[c*32 +: 32] == ibp_addr_ff[b])
					!= ibp_inv_ff[b])) begin
					nxt_hit = 1'b1;
					nxt_core = 8'(c);
					nxt_idx = 2'(b);
				end
			end
		end
	end

	// breakpoint request is not raised while already in debug
	always_ff @(posedge clk) begin
		if (rst) begin
			ibp_hit <= 1'b0;
			ibp_core <= 8'h00;
			ibp_index <= 2'h0;
		end else begin
			ibp_hit <= nxt_hit && !debug_mode;
			ibp_core <= nxt_core;
			ibp_index <= nxt_idx;
		end
	end

	// breakpoint register writes
	for (genvar i = 0; i < NIBP; i++) begin : g_ibp
		always_ff @(posedge clk) begin
			if (rst) begin
				ibp_addr_ff[i] <= dbg_unit_pkg::RST_WORD;
				ibp_en_ff[i] <= 1'b0;
				ibp_inv_ff[i] <= 1'b0;
				ibp_cores_ff[i] <= 8'h00;
			end else begin
				if (dbg_wr && hit(req.addr,
						dbg_unit_pkg::OFS_IBP_ADDR + 8'(i))) begin
					ibp_addr_ff[i] <= req.wdata;
				end
				// only defined control fields are kept
				if (dbg_wr && hit(req.addr,
						dbg_unit_pkg::OFS_IBP_CTRL + 8'(i))) begin
					ibp_en_ff[i] <= req.wdata[dbg_unit_pkg::CTRL_EN_BIT];
					ibp_inv_ff[i] <= req.wdata[dbg_unit_pkg::CTRL_INV_BIT];
					ibp_cores_ff[i] <=
						req.wdata[dbg_unit_pkg::CTRL_CORE_LSB +: 8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// cause register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cause_code_ff <= 3'h0;
			cause_core_ff <= 8'h00;
			cause_idx_ff <= 2'h0;
		end else if (entry.valid) begin
			cause_code_ff <= entry.cause;
			cause_core_ff <= entry.core_valid ? entry.core : 8'h00;
			// lowest hardware index, from pipeline or ibp match
			if (entry.cause == dbg_unit_pkg::CAUSE_IBP) begin
				cause_idx_ff <= ibp_index;
			end else if (entry.cause == dbg_unit_pkg::CAUSE_DWP ||
					entry.cause == dbg_unit_pkg::CAUSE_RWP) begin
				cause_idx_ff <= entry.wp_idx;
			end else begin
				cause_idx_ff <= 2'h0;
			end
		end else if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_CAUSE)) begin
			cause_code_ff <= req.wdata[2:0];
			cause_core_ff <= req.wdata[dbg_unit_pkg::CAUSE_CORE_LSB +: 8];
			cause_idx_ff <= req.wdata[dbg_unit_pkg::CAUSE_IDX_LSB +: 2];
		end
	end

	// ----------------------------------------------------------------
	// halt mask and per-core halt
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			halt_ff <= 8'h00;
		end else if (dbg_wr && hit(req.addr, dbg_unit_pkg::OFS_HALT)) begin
			halt_ff <= req.wdata[7:0];
		end
	end

	// masked cores stay stopped outside debug mode
	// single-step relies on the debugger masking other cores
	always_ff @(posedge clk) begin
		if (rst) begin
			core_halt <= '0;
		end else begin
			core_halt <= debug_mode ? '0 : halt_ff[NCORES-1:0];
		end
	end

	// ----------------------------------------------------------------
	// scratch words, shared with tile config port
	// ----------------------------------------------------------------
	// one storage, two writers; config port loses a collision
	for (genvar s = 0; s < NSCR; s++) begin : g_scr
		always_ff @(posedge clk) begin
			if (rst) begin
				scratch_ff[s] <= dbg_unit_pkg::RST_WORD;
			end else if (dbg_wr && hit(req.addr,
					dbg_unit_pkg::OFS_SCRATCH + 8'(s))) begin
				scratch_ff[s] <= req.wdata;
			end else if (cfg_wr && cfg_idx == 3'(s)) begin
				scratch_ff[s] <= cfg_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_rdata <= dbg_unit_pkg::RST_WORD;
		end else begin
			cfg_rdata <= scratch_ff[cfg_idx];
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: bit0 debug entry, bit1 breakpoint match
	// ----------------------------------------------------------------
	logic [1:0] ev_now;
	logic stat_rd;
	assign ev_now = {ibp_hit, entry.valid};
	assign stat_rd = req.rd && hit(req.addr, dbg_unit_pkg::OFS_IRQ_STAT);

	// set wins over the read clear
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat_ff <= 2'h0;
		end else begin
			irq_stat_ff <= (stat_rd ? 2'h0 : irq_stat_ff) | ev_now;
		end
	end

	// mask is plain read-write, not limited to debug mode
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_ff <= 2'h0;
		end else if (req.wr && hit(req.addr, dbg_unit_pkg::OFS_IRQ_MASK)) begin
			irq_mask_ff <= req.wdata[1:0];
		end
	end

	// level output follows status on the same edge, gated by the mask held before that edge
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((stat_rd ? 2'h0 : irq_stat_ff) | ev_now) & irq_mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// read mux, data the cycle after the strobe
	// ----------------------------------------------------------------
	logic [31:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		// reserved bits and unmapped indices read zero
		unique case (req.addr)
			dbg_unit_pkg::OFS_SPC: nxt_rdata = spc_ff;
			dbg_unit_pkg::OFS_SSP: nxt_rdata = ssp_ff;
			dbg_unit_pkg::OFS_RR_CORE: nxt_rdata = {24'h0, rr_core_ff};
			dbg_unit_pkg::OFS_RR_IDX: nxt_rdata = {27'h0, rr_idx_ff};
			dbg_unit_pkg::OFS_CAUSE: nxt_rdata = {14'h0, cause_idx_ff,
				cause_core_ff, 5'h0, cause_code_ff};
			dbg_unit_pkg::OFS_EVDATA: nxt_rdata = evdata_ff;
			dbg_unit_pkg::OFS_HALT: nxt_rdata = {24'h0, halt_ff};
			dbg_unit_pkg::OFS_IRQ_STAT: nxt_rdata = {30'h0, irq_stat_ff};
			dbg_unit_pkg::OFS_IRQ_MASK: nxt_rdata = {30'h0, irq_mask_ff};
			default: begin
				if (req.addr[7:3] == dbg_unit_pkg::OFS_SCRATCH[7:3]) begin
					nxt_rdata = scratch_ff[req.addr[2:0]];
				end else if (req.addr[7:2] == dbg_unit_pkg::OFS_IBP_ADDR[7:2])
						begin
					nxt_rdata = ibp_addr_ff[req.addr[1:0]];
				end else if (req.addr[7:2] == dbg_unit_pkg::OFS_IBP_CTRL[7:2])
						begin
					nxt_rdata = {8'h0, ibp_cores_ff[req.addr[1:0]], 14'h0,
						ibp_inv_ff[req.addr[1:0]], ibp_en_ff[req.addr[1:0]]};
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= req.rd ? nxt_rdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_SPC_CAPTURE: assert property (
		entry.valid |=> spc_ff == $past(entry.saved_program_counter))
		else $error("saved pc not captured");
	AST_SSP_CAPTURE: assert property (
		entry.valid |=> ssp_ff == $past(entry.saved_stack_pointer))
		else $error("saved sp not captured");
	AST_RR_READ: assert property (
		req.rd && req.addr == dbg_unit_pkg::OFS_RR_CORE |=> rdata[31:8] == 0)
		else $error("core select upper bits nonzero");
	AST_CAUSE: assert property (
		entry.valid |=> cause_code_ff == $past(entry.cause))
		else $error("cause code wrong");
	AST_CORE_ZERO: assert property (
		entry.valid && !entry.core_valid |=> cause_core_ff == 8'h00)
		else $error("cause core not zero");
	AST_EVDATA: assert property (
		entry.valid && entry.cause == dbg_unit_pkg::CAUSE_DWP
		|=> evdata_ff == $past(entry.ev_data))
		else $error("event data not loaded");
	AST_HALT: assert property (
		!debug_mode |=> core_halt == $past(halt_ff[NCORES-1:0]))
		else $error("halt mask not applied");
	AST_NO_WR_OUT: assert property (
		req.wr && !debug_mode && req.addr == dbg_unit_pkg::OFS_HALT
		&& !rst |=> $stable(halt_ff))
		else $error("write accepted outside debug");
	AST_IBP_DIS: assert property (
		!ibp_en_ff[0] && !ibp_en_ff[1] && !ibp_en_ff[2] && !ibp_en_ff[3]
		|=> !ibp_hit)
		else $error("disabled breakpoint fired");
	AST_IRQ: assert property (
		irq |-> ##0 $past(irq_mask_ff) != 2'h0)
		else $error("irq with empty mask");

	COV_IBP: cover property (ibp_hit ##[1:4] entry.valid);
	COV_DWP: cover property (entry.valid &&
		entry.cause == dbg_unit_pkg::CAUSE_DWP);
	COV_STEP: cover property (!debug_mode && core_halt != 0);
	COV_SCR: cover property (cfg_wr ##1 req.rd);

endmodule

// file: shared/dbg_unit_pkg.sv
// package for the per-tile debug support block: offsets, fields, types
// assumes a plain register port with word indices as printed addresses
//
// Overview of operation
// - on debug entry copy the thread's saved program counter, readable and writable
// - on debug entry copy the thread's saved stack pointer, readable and writable
// - register-read core select holds 8-bit core number, upper bits zero
// - register-read index holds 5-bit register number, upper bits zero
// - 3-bit cause: 1 host, 2 debug call, 3 ibp, 4 data, 5 resource
// - cause bits 17:16 hold lowest firing breakpoint or watchpoint index
// - cause bits 15:8 hold causing core number, else zero
// - data watchpoint hit loads event data with the effective address
// - resource watchpoint hit loads event data with the resource id
// - halt mask stops flagged cores whenever debug mode is inactive
// - eight 32-bit scratch words, also reachable from tile config port
// - four instruction breakpoints fire when core pc matches address
// - control bit 0 enables the breakpoint, reset zero
// - control bit 1 inverts the match to pc not equal
// - control bits 23:16 enable per core, reset zero
package dbg_unit_pkg;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SPC = 8'h11;
	localparam logic [7:0] OFS_SSP = 8'h12;
	localparam logic [7:0] OFS_RR_CORE = 8'h13;
	localparam logic [7:0] OFS_RR_IDX = 8'h14;
	localparam logic [7:0] OFS_CAUSE = 8'h15;
	localparam logic [7:0] OFS_EVDATA = 8'h16;
	localparam logic [7:0] OFS_HALT = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1a;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1b;
	localparam logic [7:0] OFS_SCRATCH = 8'h20;
	localparam logic [7:0] OFS_IBP_ADDR = 8'h30;
	localparam logic [7:0] OFS_IBP_CTRL = 8'h40;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_INV_BIT = 1;
	localparam int CTRL_CORE_LSB = 16;
	localparam int CAUSE_CORE_LSB = 8;
	localparam int CAUSE_IDX_LSB = 16;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] NUM_EVENTS = 2'h2;

	// cause codes
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_HOST = 3'h1,
		CAUSE_DEBUG_CALL_INSTR = 3'h2,
		CAUSE_IBP = 3'h3,
		CAUSE_DWP = 3'h4,
		CAUSE_RWP = 3'h5
	} cause_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	// entry request from the core pipeline
	typedef struct packed {
		logic valid;
		cause_t cause;
		logic core_valid;
		logic [7:0] core;
		logic [1:0] wp_idx;
		logic [31:0] saved_program_counter;
		logic [31:0] saved_stack_pointer;
		logic [31:0] ev_data;
	} entry_req_t;

endpackage

// file: dv/core_pipe_model.sv
// model of the cores that sit behind the debug block
// assumes the bench pulses step to retire one instruction per running core
module core_pipe_model #(
	parameter int NCORES = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// halt from the block, step from the bench
	input wire logic [NCORES-1:0] core_halt,
	input wire logic step,
	// pc report to the block
	output logic [NCORES*32-1:0] core_pc,
	output logic [NCORES-1:0] core_pc_valid
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] pc_ff [NCORES];

	// ------------------------------------------------------------
	// program counters
	// ------------------------------------------------------------
	// halted cores hold
	always_ff @(posedge clk) begin
		for (int c = 0; c < NCORES; c++) begin
			if (rst) begin
				pc_ff[c] <= 32'h0000_1000 + 32'(c) * 32'h0000_0100;
			end else if (step && !core_halt[c]) begin
				pc_ff[c] <= pc_ff[c] + 32'h0000_0004;
			end
		end
	end

	// flat pc bus, core c at c*32
	always_comb begin
		for (int c = 0; c < NCORES; c++) begin
			core_pc[c*32 +: 32] = pc_ff[c];
		end
	end

	// a stopped core issues nothing, so its pc cannot match
	assign core_pc_valid = ~core_halt;
endmodule

// file: dv/tb_top.sv
// self-checking bench for the debug support block
// assumes the register port answers one cycle after a read strobe
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
	$display("wrong value %s exp %h got %h", nm, ex, gt); \
	n_mismatch++; end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst, cfg_wr, debug_mode, step, ibp_hit, irq;
	dbg_unit_pkg::reg_req_t req;
	dbg_unit_pkg::entry_req_t entry;
	logic [31:0] rdata, cfg_rdata, cfg_wdata, rd_val;
	logic [2:0] cfg_idx;
	logic [255:0] core_pc;
	logic [7:0] core_pc_valid, core_halt, ibp_core;
	logic [1:0] ibp_index;
	int n_mismatch, n_compared;
	logic [7:0] wa [10] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
		8'h18, 8'h27, 8'h33, 8'h43};
	logic [31:0] we [10] = '{32'ha5a5_5a5a, 32'ha5a5_5a5a, 32'h0000_005a,
		32'h0000_001a, 32'h0001_5a02, 32'ha5a5_5a5a, 32'h0000_005a,
		32'ha5a5_5a5a, 32'ha5a5_5a5a, 32'h00a5_0002};

	dbg_unit #(.NCORES(8), .NIBP(4), .NSCR(8)) uut (.clk(clk), .rst(rst),
		.req(req), .rdata(rdata), .cfg_wr(cfg_wr), .cfg_idx(cfg_idx),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.debug_mode(debug_mode), .entry(entry), .core_pc(core_pc),
		.core_pc_valid(core_pc_valid), .ibp_hit(ibp_hit),
		.ibp_core(ibp_core), .ibp_index(ibp_index),
		.core_halt(core_halt), .irq(irq));

	core_pipe_model #(.NCORES(8)) pipe (.clk(clk), .rst(rst),
		.core_halt(core_halt), .step(step), .core_pc(core_pc),
		.core_pc_valid(core_pc_valid));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic chk(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		rd_val = rdata;
		`CHK($sformatf("reg %h", a), ex, rd_val)
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic mode(input logic m);
		@(posedge clk);
		debug_mode <= m;
	endtask

	// entry pulse, then check the captured copies
	task automatic ent(input dbg_unit_pkg::cause_t c, input logic cv,
		input logic [7:0] k, input logic [1:0] x, input logic [31:0] ev,
		input logic [31:0] ev_ex, input logic [1:0] x_ex);
		@(posedge clk);
		entry <= '{valid: 1'b1, cause: c, core_valid: cv, core: k,
			wp_idx: x, saved_program_counter: ev ^ 32'h1111_1111, saved_stack_pointer: ev ^ 32'h2222_2222,
			ev_data: ev};
		@(posedge clk);
		entry.valid <= 1'b0;
		chk(8'h11, ev ^ 32'h1111_1111);
		chk(8'h12, ev ^ 32'h2222_2222);
		chk(8'h15, {14'h0, x_ex, cv ? k : 8'h00, 5'h0, c});
		chk(8'h16, ev_ex);
	endtask

	// leave debug mode, look at the match, come back
	task automatic bp(input logic h, input logic [1:0] x, input logic [7:0] k);
		mode(1'b0);
		cyc(3);
		`CHK("ibp_hit", h, ibp_hit)
		if (h) begin
			`CHK("ibp_index", x, ibp_index)
			`CHK("ibp_core", k, ibp_core)
		end
		mode(1'b1);
		cyc(2);
		`CHK("ibp_hit in debug", 1'b0, ibp_hit)
	endtask

	task automatic close_out();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard, about forty times the expected run
	initial begin
		#50000;
		n_mismatch++;
		close_out();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		req = '0;
		entry = '0;
		cfg_wr = 1'b0;
		cfg_idx = 3'h0;
		cfg_wdata = 32'h0;
		debug_mode = 1'b0;
		step = 1'b0;
		rst = 1'b1;
		n_mismatch = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) chk(8'h40 + 8'(i), 32'h0);
		chk(8'h15, 32'h0);
		chk(8'h17, 32'h0);
		`CHK("irq", 1'b0, irq)
		// field masking of every register kind except interrupt status and mask
		mode(1'b1);
		for (int i = 0; i < 10; i++) begin
			wr(wa[i], 32'ha5a5_5a5a);
			chk(wa[i], we[i]);
		end
		wr(8'h18, 32'h0);
		wr(8'h43, 32'h0);
		// scratch shared with the config port
		@(posedge clk);
		cfg_idx <= 3'h7;
		cyc(2);
		`CHK("cfg_rdata", 32'ha5a5_5a5a, cfg_rdata)
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_idx <= 3'h0;
		cfg_wdata <= 32'h0bad_f00d;
		@(posedge clk);
		cfg_wr <= 1'b0;
		chk(8'h20, 32'h0bad_f00d);
		// writes dropped outside debug mode
		mode(1'b0);
		wr(8'h11, 32'h0);
		wr(8'h27, 32'h0);
		chk(8'h11, 32'ha5a5_5a5a);
		chk(8'h27, 32'ha5a5_5a5a);
		mode(1'b1);
		// entry captures per cause; event data only on watchpoints
		ent(dbg_unit_pkg::CAUSE_DWP, 1'b1, 8'h03, 2'h2, 32'hdead_0001,
			32'hdead_0001, 2'h2);
		ent(dbg_unit_pkg::CAUSE_RWP, 1'b1, 8'h07, 2'h1, 32'h0000_0042,
			32'h0000_0042, 2'h1);
		ent(dbg_unit_pkg::CAUSE_HOST, 1'b0, 8'h05, 2'h3, 32'h7777_0000,
			32'h0000_0042, 2'h0);
		ent(dbg_unit_pkg::CAUSE_DEBUG_CALL_INSTR, 1'b1, 8'h01, 2'h3, 32'h7777_0001,
			32'h0000_0042, 2'h0);
		// interrupt: sticky status, read clears, mask gates
		wr(8'h1b, 32'h1);
		chk(8'h1a, 32'h1);
		cyc(2);
		`CHK("irq cleared", 1'b0, irq)
		ent(dbg_unit_pkg::CAUSE_HOST, 1'b0, 8'h00, 2'h0, 32'h0,
			32'h0000_0042, 2'h0);
		`CHK("irq raised", 1'b1, irq)
		chk(8'h1a, 32'h1);
		cyc(2);
		`CHK("irq after read", 1'b0, irq)
		wr(8'h1b, 32'h0);
		ent(dbg_unit_pkg::CAUSE_HOST, 1'b0, 8'h00, 2'h0, 32'h0,
			32'h0000_0042, 2'h0);
		`CHK("irq masked", 1'b0, irq)
		chk(8'h1a, 32'h1);
		// breakpoints on core 2 pc
		wr(8'h31, 32'h0000_1200);
		wr(8'h32, 32'h0000_1200);
		wr(8'h41, 32'h0004_0001);
		wr(8'h42, 32'h0004_0001);
		bp(1'b1, 2'h1, 8'h02);
		wr(8'h41, 32'h0000_0001);
		bp(1'b1, 2'h2, 8'h02);
		wr(8'h42, 32'h0004_0000);
		bp(1'b0, 2'h0, 8'h00);
		wr(8'h30, 32'h0000_1200);
		wr(8'h40, 32'h0004_0003);
		bp(1'b0, 2'h0, 8'h00);
		wr(8'h40, 32'h0020_0003);
		bp(1'b1, 2'h0, 8'h05);
		// single step core 2, all others held
		wr(8'h40, 32'h0);
		wr(8'h18, 32'h0000_01fb);
		`CHK("core_halt in debug", 8'h00, core_halt)
		wr(8'h31, 32'h0000_1304);
		wr(8'h41, 32'h0008_0001);
		wr(8'h32, 32'h0000_1204);
		wr(8'h42, 32'h0004_0001);
		mode(1'b0);
		cyc(3);
		`CHK("core_halt", 8'hfb, core_halt)
		`CHK("ibp_hit before step", 1'b0, ibp_hit)
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		cyc(3);
		`CHK("ibp_hit stepped", 1'b1, ibp_hit)
		`CHK("ibp_index stepped", 2'h2, ibp_index)
		mode(1'b1);
		cyc(2);
		close_out();
	end
endmodule
